// *** core/pfcr_pkg.sv ***
// Package for the power-manager function control register bank.
// Assumes an 8-bit index register port on the system clock.
package pfcr_pkg;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CLK_ACT = 8'hAD;
  localparam logic [7:0] IDX_TMR_DOZE = 8'hAF;
  localparam logic [7:0] IDX_PORT_EN = 8'hB0;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_TIMER0_SMI = 6;
  localparam int B_PWR_ACT = 4;
  localparam int B_KBD_EMU = 3;
  localparam int B_FAST_STOP = 2;
  localparam int B_SLOW_HI = 1;
  localparam int B_SLOW_LO = 0;
  localparam int B_SLOW_DOZE_UNIT = 7;
  localparam int B_FAST_SLOW_UNIT = 6;
  localparam int B_BATT_SLOW = 5;
  localparam int B_DOZE_EXTEND = 0;
  localparam int B_XTAL_SRC = 6;
  localparam int B_SMI_POL = 5;
  localparam int B_SMI_EN = 4;
  localparam int B_DMA_STOP = 3;
  localparam int B_EPP = 2;
  localparam int B_BUF_CFG = 1;
  localparam int B_BIDIR = 0;
  localparam logic [7:0] PORT_EN_READ_MASK = 8'hBF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DOZE_EXTEND_REFRESH = 64;

  typedef enum logic [1:0] {
    PFCR_FAST = 2'h0,
    PFCR_SLOW = 2'h1,
    PFCR_DOZE = 2'h3,
    PFCR_DEEP = 2'h2
  } pfcr_mode_t;

  typedef enum logic [1:0] {
    PFCR_PORT_OUT_NOBUF = 2'h0,
    PFCR_PORT_OUT_BUF = 2'h1,
    PFCR_PORT_BIDIR = 2'h3,
    PFCR_PORT_EPP = 2'h2
  } pfcr_port_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfcr_bus_t;

endpackage

// *** core/pfcr_regs.sv ***
// Power-manager function control register bank and its control decodes.
// Assumes pins already reach clk_i's domain only through the synchronisers here.
//
// Notes on behaviour
// - Slow field picks 9.216 to 1.152 MHz
// - Slow field only acts in slow mode
// - Timer 0 expiry raises SMI when set and the PIC enables IRQ0
// - Power-present input counts as activity
// - Mask bit 6 dead when enable zero
// - Keyboard emulation floats pins, internal decode
// - Fast PLL stops in slow or doze
// - Slow-to-doze unit quarter or sixteenth
// - Fast-to-slow unit sixteenth or 1/512
// - Battery low slows fast mode clock
// - Doze extends 64 refreshes after IRQ0
// - Crystal pin source select, write only
// - External SMI polarity select
// - External SMI accepted only when enabled
// - DMA clock runs only during access
// - No buffer enable when config zero
// - Bidir bit controls latch output enable
// - Three bits select port mode, invalids flagged
// - EPP bit enables enhanced port
// - All bits reset to zero
`timescale 1ns/1ps
module pfcr_regs #(
  parameter int REFRESH_CNT = pfcr_pkg::DOZE_EXTEND_REFRESH
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire pfcr_pkg::pfcr_bus_t bus_i,
  output logic [7:0] rdata_o,
  input wire pfcr_pkg::pfcr_mode_t mode_i,
  input wire logic timer0_expire_i,
  input wire logic irq0_pic_enable_i,
  input wire logic external_power_present_i,
  input wire logic battery_low_first_input_i,
  input wire logic activity_mask_bit6_i,
  input wire logic refresh_tick_i,
  input wire logic mmsb_extend_enable_i,
  input wire logic ext_sysmgmt_irq_i,
  input wire logic serial_baud_clock_i,
  input wire logic xtal_use_i,
  input wire logic dma_active_i,
  input wire logic port_access_i,
  input wire logic port_ctrl_bit5_i,
  input wire logic kbd_internal_irq_i,
  input wire logic kbd_pin_irq_i,
  output logic [1:0] cpu_clock_sel_o,
  output logic cpu_slow_force_o,
  output logic fast_pll_stop_o,
  output logic sysmgmt_timer_irq_o,
  output logic irq0_o,
  output logic power_activity_o,
  output logic keyboard_ctrl_select_pin_oe_o,
  output logic bus_clock_pin_oe_o,
  output logic port60_internal_o,
  output logic irq1_o,
  output logic slow_to_doze_quarter_o,
  output logic fast_to_slow_sixteenth_o,
  output logic doze_cpu_run_o,
  output logic crystal_output_pin_o,
  output logic ext_sysmgmt_irq_o,
  output logic dma_clock_run_o,
  output logic system_buffer_output_enable_o,
  output logic port_latch_output_enable_o,
  output pfcr_pkg::pfcr_port_mode_t port_mode_o,
  output logic port_mode_invalid_o
);

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [7:0] clk_act;
  logic [7:0] tmr_doze;
  logic [7:0] port_en;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_act <= pfcr_pkg::RESET_VAL;
      tmr_doze <= pfcr_pkg::RESET_VAL;
      port_en <= pfcr_pkg::RESET_VAL;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        pfcr_pkg::IDX_CLK_ACT: clk_act <= bus_i.wdata;
        pfcr_pkg::IDX_TMR_DOZE: tmr_doze <= bus_i.wdata;
        pfcr_pkg::IDX_PORT_EN: port_en <= bus_i.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        pfcr_pkg::IDX_CLK_ACT: rdata_o <= clk_act;
        pfcr_pkg::IDX_TMR_DOZE: rdata_o <= tmr_doze;
        pfcr_pkg::IDX_PORT_EN: rdata_o <= port_en & pfcr_pkg::PORT_EN_READ_MASK;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Only off-chip pins pass here; internal timer/refresh inputs are same-clock.
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s1;
  logic [NSYNC-1:0] pin_s2;
  assign pin_raw = {external_power_present_i, battery_low_first_input_i,
                    ext_sysmgmt_irq_i, kbd_pin_irq_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  logic pwr_present;
  logic batt_low_n;
  logic smi_pin;
  logic kbd_pin;
  assign pwr_present = pin_s2[3];
  assign batt_low_n = pin_s2[2];
  assign smi_pin = pin_s2[1];
  assign kbd_pin = pin_s2[0];

  // ----------------------------------------------------------------
  // Clock and power-manager controls
  // ----------------------------------------------------------------
  // Slow-field value latched on slow-mode entry so mid-mode writes wait.
  logic [1:0] slow_sel_live;
  pfcr_pkg::pfcr_mode_t mode_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= pfcr_pkg::PFCR_FAST;
      slow_sel_live <= 2'h0;
    end else begin
      mode_q <= mode_i;
      if (mode_i == pfcr_pkg::PFCR_SLOW && mode_q != pfcr_pkg::PFCR_SLOW) begin
        slow_sel_live <= {clk_act[pfcr_pkg::B_SLOW_HI], clk_act[pfcr_pkg::B_SLOW_LO]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_clock_sel_o <= 2'h0;
      cpu_slow_force_o <= 1'b0;
      fast_pll_stop_o <= 1'b0;
    end else begin
      // 0..3 = 9.216, 4.608, 2.304, 1.152 MHz; core runs at half
      if (mode_i == pfcr_pkg::PFCR_SLOW && mode_q != pfcr_pkg::PFCR_SLOW) begin
        // Entry cycle takes the field directly, so no stale select leaks out
        cpu_clock_sel_o <= {clk_act[pfcr_pkg::B_SLOW_HI], clk_act[pfcr_pkg::B_SLOW_LO]};
      end else if (mode_i == pfcr_pkg::PFCR_SLOW) begin
        cpu_clock_sel_o <= slow_sel_live;
      end else begin
        cpu_clock_sel_o <= 2'h0;
      end
      cpu_slow_force_o <= tmr_doze[pfcr_pkg::B_BATT_SLOW] && mode_i == pfcr_pkg::PFCR_FAST
                          && !batt_low_n && !pwr_present;
      if (clk_act[pfcr_pkg::B_FAST_STOP]) begin
        fast_pll_stop_o <= mode_i != pfcr_pkg::PFCR_FAST;
      end else begin
        fast_pll_stop_o <= mode_i == pfcr_pkg::PFCR_DOZE || mode_i == pfcr_pkg::PFCR_DEEP;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slow_to_doze_quarter_o <= 1'b0;
      fast_to_slow_sixteenth_o <= 1'b0;
      power_activity_o <= 1'b0;
    end else begin
      slow_to_doze_quarter_o <= tmr_doze[pfcr_pkg::B_SLOW_DOZE_UNIT];
      fast_to_slow_sixteenth_o <= tmr_doze[pfcr_pkg::B_FAST_SLOW_UNIT];
      // Mask bit gated by enable, so it cannot act alone
      power_activity_o <= clk_act[pfcr_pkg::B_PWR_ACT] && activity_mask_bit6_i
                          && pwr_present;
    end
  end

  // ----------------------------------------------------------------
  // Timer 0 redirection and external SMI
  // ----------------------------------------------------------------
  logic smi_active;
  assign smi_active = smi_pin ^ port_en[pfcr_pkg::B_SMI_POL];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sysmgmt_timer_irq_o <= 1'b0;
      irq0_o <= 1'b0;
      ext_sysmgmt_irq_o <= 1'b0;
    end else begin
      if (clk_act[pfcr_pkg::B_TIMER0_SMI]) begin
        sysmgmt_timer_irq_o <= timer0_expire_i && irq0_pic_enable_i;
        irq0_o <= 1'b0;
      end else begin
        sysmgmt_timer_irq_o <= 1'b0;
        irq0_o <= timer0_expire_i;
      end
      ext_sysmgmt_irq_o <= port_en[pfcr_pkg::B_SMI_EN] && smi_active;
    end
  end

  // ----------------------------------------------------------------
  // Keyboard emulation
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      keyboard_ctrl_select_pin_oe_o <= 1'b0;
      bus_clock_pin_oe_o <= 1'b0;
      port60_internal_o <= 1'b0;
      irq1_o <= 1'b0;
    end else begin
      // Enables low means driving; high floats the pin as an input
      keyboard_ctrl_select_pin_oe_o <= clk_act[pfcr_pkg::B_KBD_EMU];
      bus_clock_pin_oe_o <= clk_act[pfcr_pkg::B_KBD_EMU];
      port60_internal_o <= clk_act[pfcr_pkg::B_KBD_EMU];
      irq1_o <= clk_act[pfcr_pkg::B_KBD_EMU] ? kbd_internal_irq_i : kbd_pin;
    end
  end

  // ----------------------------------------------------------------
  // Doze run extension after IRQ0
  // ----------------------------------------------------------------
  localparam int CW = $clog2(REFRESH_CNT + 1);
  logic [CW-1:0] ext_cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_cnt <= '0;
    end else if (mode_i != pfcr_pkg::PFCR_DOZE) begin
      ext_cnt <= '0;
    end else if (timer0_expire_i && tmr_doze[pfcr_pkg::B_DOZE_EXTEND]
                 && mmsb_extend_enable_i) begin
      ext_cnt <= CW'(REFRESH_CNT);
    end else if (refresh_tick_i && ext_cnt != '0) begin
      ext_cnt <= ext_cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      doze_cpu_run_o <= 1'b0;
    end else begin
      doze_cpu_run_o <= ext_cnt != '0;
    end
  end

  // ----------------------------------------------------------------
  // Crystal pin, DMA clock, parallel port
  // ----------------------------------------------------------------
  logic bidir;
  logic bufcfg;
  logic epp;
  assign bidir = port_en[pfcr_pkg::B_BIDIR];
  assign bufcfg = port_en[pfcr_pkg::B_BUF_CFG];
  assign epp = port_en[pfcr_pkg::B_EPP];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crystal_output_pin_o <= 1'b0;
      dma_clock_run_o <= 1'b0;
      system_buffer_output_enable_o <= 1'b0;
      port_latch_output_enable_o <= 1'b0;
    end else begin
      crystal_output_pin_o <= port_en[pfcr_pkg::B_XTAL_SRC] ? serial_baud_clock_i
                                                            : xtal_use_i;
      dma_clock_run_o <= !port_en[pfcr_pkg::B_DMA_STOP] || dma_active_i;
      system_buffer_output_enable_o <= bufcfg && port_access_i;
      // Bidir bit ignored without buffer config: latch keeps driving
      port_latch_output_enable_o <= bufcfg && bidir && port_ctrl_bit5_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_mode_o <= pfcr_pkg::PFCR_PORT_OUT_NOBUF;
      port_mode_invalid_o <= 1'b0;
    end else begin
      port_mode_invalid_o <= !bufcfg && (bidir || epp);
      if (bufcfg && epp) begin
        port_mode_o <= pfcr_pkg::PFCR_PORT_EPP;
      end else if (bufcfg && bidir) begin
        port_mode_o <= pfcr_pkg::PFCR_PORT_BIDIR;
      end else if (bufcfg) begin
        port_mode_o <= pfcr_pkg::PFCR_PORT_OUT_BUF;
      end else begin
        port_mode_o <= pfcr_pkg::PFCR_PORT_OUT_NOBUF;
      end
    end
  end

endmodule

// *** test/pfcr_regs_checker.sv ***
// Concurrent checks for the function control register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/1ps
module pfcr_regs_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire pfcr_pkg::pfcr_bus_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire pfcr_pkg::pfcr_mode_t mode_i,
  input wire logic dma_active_i,
  input wire logic [1:0] cpu_clock_sel_o,
  input wire logic fast_pll_stop_o,
  input wire logic irq0_o,
  input wire logic ext_sysmgmt_irq_o,
  input wire logic dma_clock_run_o,
  input wire logic system_buffer_output_enable_o
);
  logic [7:0] ctl_sh;
  logic [7:0] port_sh;
  // ----------------------------------------
  // Write shadows
  // ----------------------------------------
  // Enable bits are not visible at the ports
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_sh <= 8'h00;
    end else if (bus_i.wr && bus_i.addr == pfcr_pkg::IDX_CLK_ACT) begin
      ctl_sh <= bus_i.wdata;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_sh <= 8'h00;
    end else if (bus_i.wr && bus_i.addr == pfcr_pkg::IDX_PORT_EN) begin
      port_sh <= bus_i.wdata;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  property p_sel_off;
    mode_i != pfcr_pkg::PFCR_SLOW |=> cpu_clock_sel_o == 2'h0;
  endproperty
  a_sel_off: assert property (p_sel_off)
    else $error("clock select set outside slow mode");
  property p_sel_hold;
    mode_i == pfcr_pkg::PFCR_SLOW && $past(mode_i) == pfcr_pkg::PFCR_SLOW
      |=> $stable(cpu_clock_sel_o);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("clock select moved inside slow mode");
  property p_doze_pll;
    mode_i == pfcr_pkg::PFCR_DOZE |=> fast_pll_stop_o;
  endproperty
  a_doze_pll: assert property (p_doze_pll)
    else $error("fast pll running in doze");
  property p_irq0_redirect;
    ctl_sh[6] |=> !irq0_o;
  endproperty
  a_irq0_redirect: assert property (p_irq0_redirect)
    else $error("timer interrupt not redirected");
  property p_ext_smi_off;
    !port_sh[4] |=> !ext_sysmgmt_irq_o;
  endproperty
  a_ext_smi_off: assert property (p_ext_smi_off)
    else $error("external interrupt while disabled");
  property p_dma_stop;
    port_sh[3] && !dma_active_i |=> !dma_clock_run_o;
  endproperty
  a_dma_stop: assert property (p_dma_stop)
    else $error("dma clock running between transfers");
  property p_buf_off;
    !port_sh[1] |=> !system_buffer_output_enable_o;
  endproperty
  a_buf_off: assert property (p_buf_off)
    else $error("buffer enable without buffer config");
  property p_wo_bit;
    bus_i.rd && bus_i.addr == pfcr_pkg::IDX_PORT_EN |=> !rdata_o[6];
  endproperty
  a_wo_bit: assert property (p_wo_bit)
    else $error("write-only bit visible on read");
endmodule

bind pfcr_regs pfcr_regs_checker u_pfcr_regs_checker (
  .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o), .mode_i(mode_i),
  .dma_active_i(dma_active_i), .cpu_clock_sel_o(cpu_clock_sel_o),
  .fast_pll_stop_o(fast_pll_stop_o), .irq0_o(irq0_o), .ext_sysmgmt_irq_o(ext_sysmgmt_irq_o),
  .dma_clock_run_o(dma_clock_run_o),
  .system_buffer_output_enable_o(system_buffer_output_enable_o)
);

// *** test/pfcr_regs_tb_top.sv ***
// Self-checking bench for the function control register bank.
// Assumes every output is registered and pins pass a two-flop sync.
`timescale 1ns/1ps
module pfcr_regs_tb_top;
  typedef struct packed {
    logic [23:0] regs;
    logic [14:0] ins;
    logic [21:0] outs;
  } pfcr_row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  pfcr_pkg::pfcr_bus_t bus_i = '0;
  logic [14:0] in_v = '0;
  logic tick = 1'b0;
  logic mmsb = 1'b0;
  wire [7:0] rdata_o;
  wire [21:0] obs;
  int failures = 0;
  int check_count = 0;
  logic [7:0] idx [4] = '{pfcr_pkg::IDX_CLK_ACT, pfcr_pkg::IDX_TMR_DOZE,
    pfcr_pkg::IDX_PORT_EN, 8'hAE};
  logic [7:0] full [4] = '{8'hFF, 8'hFF, 8'hBF, 8'h00};
  // Rows: AD/AF/B0 values, input pins, expected outputs
  pfcr_row_t rows [7] = '{
    '{24'h5EE07B, 15'h3F4E, 22'h26FEDE},
    '{24'h032016, 15'h19FD, 22'h0908F4},
    '{24'h100009, 15'h671C, 22'h048021},
    '{24'h014022, 15'h220E, 22'h100232},
    '{24'h048007, 15'h4208, 22'h040434},
    '{24'h000005, 15'h020C, 22'h000021},
    '{24'h000004, 15'h020C, 22'h000021}
  };

  // Short doze count keeps the run brief
  pfcr_regs #(.REFRESH_CNT(4)) u_pfcr_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .mode_i(pfcr_pkg::pfcr_mode_t'(in_v[14:13])), .timer0_expire_i(in_v[12]),
    .irq0_pic_enable_i(in_v[11]), .external_power_present_i(in_v[10]),
    .battery_low_first_input_i(in_v[9]), .activity_mask_bit6_i(in_v[8]),
    .refresh_tick_i(tick), .mmsb_extend_enable_i(mmsb), .ext_sysmgmt_irq_i(in_v[7]),
    .serial_baud_clock_i(in_v[6]), .xtal_use_i(in_v[5]), .dma_active_i(in_v[4]),
    .port_access_i(in_v[3]), .port_ctrl_bit5_i(in_v[2]), .kbd_internal_irq_i(in_v[1]),
    .kbd_pin_irq_i(in_v[0]), .cpu_clock_sel_o(obs[21:20]), .cpu_slow_force_o(obs[19]),
    .fast_pll_stop_o(obs[18]), .sysmgmt_timer_irq_o(obs[17]), .irq0_o(obs[16]),
    .power_activity_o(obs[15]), .keyboard_ctrl_select_pin_oe_o(obs[14]),
    .bus_clock_pin_oe_o(obs[13]), .port60_internal_o(obs[12]), .irq1_o(obs[11]),
    .slow_to_doze_quarter_o(obs[10]), .fast_to_slow_sixteenth_o(obs[9]),
    .doze_cpu_run_o(obs[8]), .crystal_output_pin_o(obs[7]), .ext_sysmgmt_irq_o(obs[6]),
    .dma_clock_run_o(obs[5]), .system_buffer_output_enable_o(obs[4]),
    .port_latch_output_enable_o(obs[3]), .port_mode_o(obs[2:1]),
    .port_mode_invalid_o(obs[0])
  );

  always #20 clk_i = ~clk_i;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    @(negedge clk_i);
    chk("read data", {14'h0, e}, {14'h0, rdata_o});
  endtask
  task automatic close_out();
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (idx[i]) rd(idx[i], 8'h00);
    foreach (idx[i]) wr(idx[i], 8'hFF);
    foreach (idx[i]) rd(idx[i], full[i]);
    foreach (rows[i]) begin
      @(posedge clk_i);
      in_v <= '0;
      wr(pfcr_pkg::IDX_CLK_ACT, rows[i].regs[23:16]);
      wr(pfcr_pkg::IDX_TMR_DOZE, rows[i].regs[15:8]);
      wr(pfcr_pkg::IDX_PORT_EN, rows[i].regs[7:0]);
      in_v <= rows[i].ins;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk("outputs", rows[i].outs, obs);
    end
    // Field written inside slow mode waits for the next entry
    @(posedge clk_i);
    in_v <= '0;
    wr(pfcr_pkg::IDX_CLK_ACT, 8'h02);
    in_v[14:13] <= 2'h1;
    repeat (3) @(posedge clk_i);
    wr(pfcr_pkg::IDX_CLK_ACT, 8'h03);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("slow select", 22'h2, {20'h0, obs[21:20]});
    @(posedge clk_i);
    in_v[14:13] <= 2'h0;
    repeat (3) @(posedge clk_i);
    in_v[14:13] <= 2'h1;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("slow entry", 22'h3, {20'h0, obs[21:20]});
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("slow select", 22'h3, {20'h0, obs[21:20]});
    wr(pfcr_pkg::IDX_TMR_DOZE, 8'h01);
    mmsb <= 1'b1;
    in_v <= 15'h6000;
    @(posedge clk_i);
    in_v[12] <= 1'b1;
    @(posedge clk_i);
    in_v[12] <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    repeat (4) begin
      chk("doze run", 22'h1, {21'h0, obs[8]});
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
    end
    chk("doze run", 22'h0, {21'h0, obs[8]});
    wr(pfcr_pkg::IDX_CLK_ACT, 8'h5E);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(pfcr_pkg::IDX_CLK_ACT, 8'h00);
    close_out();
  end
endmodule
